// ---- gpio_port_pkg.sv ----
// Package with the register map, reset values and pin bundles of the six-bit GPIO port.
package gpio_port_pkg;

    // ==========================================================
    // Widths
    localparam int PIN_W = 6;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;

    // ==========================================================
    // Register offsets
    localparam logic [3:0] OFF_PIN_LEVEL = 4'h0;
    localparam logic [3:0] OFF_OUTPUT_LATCH = 4'h1;
    localparam logic [3:0] OFF_PIN_DIRECTION = 4'h2;
    localparam logic [3:0] OFF_ANALOG_SELECT = 4'h3;
    localparam logic [3:0] OFF_WEAK_PULLUP = 4'h4;
    localparam logic [3:0] OFF_OPEN_DRAIN = 4'h5;
    localparam logic [3:0] OFF_SLEW_LIMIT = 4'h6;
    localparam logic [3:0] OFF_INPUT_THRESHOLD = 4'h7;
    localparam logic [3:0] OFF_PIN_BIT_SET = 4'h8;
    localparam logic [3:0] OFF_PIN_BIT_CLEAR = 4'h9;

    // ==========================================================
    // Field masks and positions
    localparam int INPUT_ONLY_BIT = 3;
    localparam logic [5:0] ALL_PINS = 6'h3F;
    localparam logic [5:0] DRIVEN_PINS = 6'h37;
    localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
    localparam logic [5:0] NO_PINS = 6'h00;
    localparam logic [1:0] UPPER_ZERO = 2'h0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // Reset values
    localparam logic [5:0] RST_OUTPUT_LATCH = 6'h00;
    localparam logic [5:0] RST_PIN_DIRECTION = 6'h3F;
    localparam logic [5:0] RST_ANALOG_SELECT = 6'h37;
    localparam logic [5:0] RST_WEAK_PULLUP = 6'h00;
    localparam logic [5:0] RST_OPEN_DRAIN = 6'h00;
    localparam logic [5:0] RST_SLEW_LIMIT = 6'h37;
    localparam logic [5:0] RST_INPUT_THRESHOLD = 6'h3F;

    // ==========================================================
    // Pad control bundle
    typedef struct packed {
        logic [5:0] drive_out;
        logic [5:0] drive_oe;
        logic [5:0] pullup_on;
        logic [5:0] slew_limited;
        logic [5:0] schmitt_sel;
        logic [5:0] digital_in_on;
    } pad_ctrl_t;

    // Peripheral request bundle
    typedef struct packed {
        logic [5:0] owns_pin;
        logic [5:0] data_out;
        logic [5:0] two_wire_owns;
        logic [5:0] analog_out_on;
    } periph_req_t;

endpackage

// ---- six_bit_gpio_port.sv ----
// Six-bit general purpose I/O port with per-pin direction, latch and pad controls.
//
// Overview of operation
// RULE1 - six bidirectional bits, one per pin; here only five are, bit 3 is input-only
// RULE2 - direction one disables driver, zero drives latch
// RULE3 - input-only pin undriven, direction reads one
// RULE4 - pin-level read gives pins, write sets latch
// RULE5 - bit writes sample pins, modify, store latch
// RULE6 - latch keeps newest write, reads back latch
// RULE7 - after reset pins carry the output latch
// RULE8 - enabled peripheral overrides latch, pin still readable
// RULE9 - analog output forces digital driver off
// RULE10 - analog select disables digital input buffer
// RULE11 - analog-selected pins read as zero
// RULE12 - analog select leaves digital output alone
// RULE13 - direction still controls drivers on analog pins
// RULE14 - analog select resets to analog mode
// RULE15 - open-drain only sinks, otherwise push-pull
// RULE16 - two-wire peripheral forces open-drain on its pins
// RULE17 - per-pin slew limit control bit
// RULE18 - per-pin Schmitt or TTL threshold select
// RULE19 - software changes threshold with peripherals disabled
// RULE20 - per-pin weak pull-up enable bit
// RULE21 - input-only pull-up on master clear or bit
// RULE22 - pull-up off on outputs except open-drain high
// RULE23 - input-only pin reads one with master clear
// RULE24 - eight-bit registers, upper two bits read zero
// RULE25 - pin inputs synchronised before register reads
`timescale 1ns/1ns
module six_bit_gpio_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [gpio_port_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [gpio_port_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gpio_port_pkg::DATA_W-1:0] reg_rdata,
    // Pads
    input wire logic [gpio_port_pkg::PIN_W-1:0] pin_in,
    output gpio_port_pkg::pad_ctrl_t pad_ctrl,
    // Device configuration
    input wire logic master_clear_function_enable,
    // Peripheral side
    input wire gpio_port_pkg::periph_req_t periph_req,
    output logic [gpio_port_pkg::PIN_W-1:0] periph_in
);
    import gpio_port_pkg::*;

    // ==========================================================
    // Input synchronisers
    // RULE1 six pin bits
    logic [5:0] pin_meta_ff;
    logic [5:0] pin_sync_ff;
    logic mcle_meta_ff;
    logic mcle_sync_ff;

    // RULE25 two-flop sync
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pin_meta_ff <= NO_PINS;
            pin_sync_ff <= NO_PINS;
            mcle_meta_ff <= 1'b0;
            mcle_sync_ff <= 1'b0;
        end else begin
            pin_meta_ff <= pin_in;
            pin_sync_ff <= pin_meta_ff;
            mcle_meta_ff <= master_clear_function_enable;
            mcle_sync_ff <= mcle_meta_ff;
        end
    end

    // ==========================================================
    // Control registers
    logic [5:0] output_latch_ff;
    logic [5:0] pin_direction_ff;
    logic [5:0] analog_select_ff;
    logic [5:0] weak_pullup_enable_ff;
    logic [5:0] open_drain_select_ff;
    logic [5:0] slew_limit_select_ff;
    logic [5:0] input_threshold_select_ff;

    function automatic logic wr_hit(input logic [3:0] addr, input logic wr, input logic [3:0] off);
        wr_hit = wr && (addr == off);
    endfunction

    wire logic hit_pin = wr_hit(reg_addr, reg_wr, OFF_PIN_LEVEL);
    wire logic hit_lat = wr_hit(reg_addr, reg_wr, OFF_OUTPUT_LATCH);
    wire logic hit_dir = wr_hit(reg_addr, reg_wr, OFF_PIN_DIRECTION);
    wire logic hit_ans = wr_hit(reg_addr, reg_wr, OFF_ANALOG_SELECT);
    wire logic hit_wpu = wr_hit(reg_addr, reg_wr, OFF_WEAK_PULLUP);
    wire logic hit_odc = wr_hit(reg_addr, reg_wr, OFF_OPEN_DRAIN);
    wire logic hit_slr = wr_hit(reg_addr, reg_wr, OFF_SLEW_LIMIT);
    wire logic hit_inl = wr_hit(reg_addr, reg_wr, OFF_INPUT_THRESHOLD);
    wire logic hit_bset = wr_hit(reg_addr, reg_wr, OFF_PIN_BIT_SET);
    wire logic hit_bclr = wr_hit(reg_addr, reg_wr, OFF_PIN_BIT_CLEAR);

    // ==========================================================
    // Digital pin read value
    wire logic [5:0] wdata6 = reg_wdata[5:0];
    logic [5:0] pin_read;

    // RULE11 analog reads zero
    // RULE23 input-only reads one
    // RULE10 buffer off on analog
    always_comb begin
        pin_read = pin_sync_ff & ~analog_select_ff;
        if (mcle_sync_ff) begin
            pin_read[INPUT_ONLY_BIT] = 1'b1;
        end
    end

    // RULE5 read-modify-write of pins
    // RULE4 pin write lands in latch
    // RULE6 newest write wins
    wire logic [5:0] nxt_output_latch =
        hit_lat ? (wdata6 & DRIVEN_PINS) :
        hit_pin ? (wdata6 & DRIVEN_PINS) :
        hit_bset ? ((pin_read | wdata6) & DRIVEN_PINS) :
        hit_bclr ? ((pin_read & ~wdata6) & DRIVEN_PINS) :
        output_latch_ff;

    // RULE3 direction bit stuck at one
    wire logic [5:0] nxt_pin_direction = hit_dir ? (wdata6 | INPUT_ONLY_MASK) : pin_direction_ff;
    // RULE24 only six bits stored
    wire logic [5:0] nxt_analog_select = hit_ans ? (wdata6 & DRIVEN_PINS) : analog_select_ff;
    // RULE20 per-pin pull-up bit
    wire logic [5:0] nxt_weak_pullup = hit_wpu ? wdata6 : weak_pullup_enable_ff;
    wire logic [5:0] nxt_open_drain = hit_odc ? (wdata6 & DRIVEN_PINS) : open_drain_select_ff;
    // RULE17 per-pin slew bit
    wire logic [5:0] nxt_slew_limit = hit_slr ? (wdata6 & DRIVEN_PINS) : slew_limit_select_ff;
    // RULE18 per-pin threshold bit
    wire logic [5:0] nxt_input_threshold = hit_inl ? wdata6 : input_threshold_select_ff;

    // RULE14 analog mode at reset
    // RULE7 latch selected after reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            output_latch_ff <= RST_OUTPUT_LATCH;
            pin_direction_ff <= RST_PIN_DIRECTION;
            analog_select_ff <= RST_ANALOG_SELECT;
            weak_pullup_enable_ff <= RST_WEAK_PULLUP;
            open_drain_select_ff <= RST_OPEN_DRAIN;
            slew_limit_select_ff <= RST_SLEW_LIMIT;
            input_threshold_select_ff <= RST_INPUT_THRESHOLD;
        end else begin
            output_latch_ff <= nxt_output_latch;
            pin_direction_ff <= nxt_pin_direction;
            analog_select_ff <= nxt_analog_select;
            weak_pullup_enable_ff <= nxt_weak_pullup;
            open_drain_select_ff <= nxt_open_drain;
            slew_limit_select_ff <= nxt_slew_limit;
            input_threshold_select_ff <= nxt_input_threshold;
        end
    end

    // ==========================================================
    // Pad drive logic
    // RULE8 peripheral overrides latch
    wire logic [5:0] out_value = (periph_req.owns_pin & periph_req.data_out) |
        (~periph_req.owns_pin & output_latch_ff);
    // RULE16 two-wire forces open-drain
    wire logic [5:0] od_eff = open_drain_select_ff | (periph_req.owns_pin & periph_req.two_wire_owns);
    // RULE2 direction gates driver
    // RULE13 direction rules analog pins too
    // RULE9 analog output wins
    // RULE12 analog select not used here
    wire logic [5:0] drv_allowed = ~pin_direction_ff & ~periph_req.analog_out_on & DRIVEN_PINS;
    // RULE15 open-drain only sinks
    wire logic [5:0] nxt_drive_oe = drv_allowed & (~od_eff | ~out_value);
    wire logic [5:0] nxt_drive_out = out_value & ~od_eff;

    // Pull-up: inputs follow the bit, input-only pin also on master clear; outputs only as released open-drain.
    logic [5:0] nxt_pullup;
    // RULE22 pull-up off on outputs
    // RULE21 input-only pull-up
    always_comb begin
        nxt_pullup = weak_pullup_enable_ff & (pin_direction_ff | (od_eff & out_value));
        nxt_pullup[INPUT_ONLY_BIT] = mcle_sync_ff | weak_pullup_enable_ff[INPUT_ONLY_BIT];
    end

    // ==========================================================
    // Register read data
    logic [5:0] rd_mux;
    always_comb begin
        case (reg_addr)
            OFF_PIN_LEVEL: rd_mux = pin_read;
            OFF_OUTPUT_LATCH: rd_mux = output_latch_ff;
            OFF_PIN_DIRECTION: rd_mux = pin_direction_ff;
            OFF_ANALOG_SELECT: rd_mux = analog_select_ff;
            OFF_WEAK_PULLUP: rd_mux = weak_pullup_enable_ff;
            OFF_OPEN_DRAIN: rd_mux = open_drain_select_ff;
            OFF_SLEW_LIMIT: rd_mux = slew_limit_select_ff;
            OFF_INPUT_THRESHOLD: rd_mux = input_threshold_select_ff;
            default: rd_mux = NO_PINS;
        endcase
    end

    // RULE24 upper bits zero
    wire logic [7:0] nxt_rdata = reg_rd ? {UPPER_ZERO, rd_mux} : READ_ZERO;

    // ==========================================================
    // Output registers
    logic [7:0] rdata_ff;
    pad_ctrl_t pad_ff;
    logic [5:0] periph_in_ff;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= READ_ZERO;
            pad_ff <= '0;
            periph_in_ff <= NO_PINS;
        end else begin
            rdata_ff <= nxt_rdata;
            pad_ff.drive_out <= nxt_drive_out;
            pad_ff.drive_oe <= nxt_drive_oe;
            pad_ff.pullup_on <= nxt_pullup;
            pad_ff.slew_limited <= slew_limit_select_ff;
            pad_ff.schmitt_sel <= input_threshold_select_ff;
            pad_ff.digital_in_on <= ~analog_select_ff;
            periph_in_ff <= pin_read;
        end
    end

    assign reg_rdata = rdata_ff;
    assign pad_ctrl = pad_ff;
    assign periph_in = periph_in_ff;

    // ==========================================================
    // Assertions
    property p_dir_off;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |=> ((pad_ctrl.drive_oe & $past(pin_direction_ff)) == NO_PINS);
    endproperty
    a_dir_off: assert property (p_dir_off) else $error("driver on for an input pin"); // RULE2

    property p_dir3_one;
        @(posedge mclk) disable iff (!nrst)
        (reg_rd && reg_addr == OFF_PIN_DIRECTION) |=> reg_rdata[INPUT_ONLY_BIT];
    endproperty
    a_dir3_one: assert property (p_dir3_one) else $error("input-only direction read zero"); // RULE3

    property p_latch_wr;
        @(posedge mclk) disable iff (!nrst)
        (reg_wr && reg_addr == OFF_PIN_LEVEL) ##1 (reg_rd && reg_addr == OFF_OUTPUT_LATCH)
        |=> reg_rdata[5:0] == ($past(reg_wdata[5:0], 2) & DRIVEN_PINS);
    endproperty
    a_latch_wr: assert property (p_latch_wr) else $error("latch lost pin-level write"); // RULE6

    property p_analog_zero;
        @(posedge mclk) disable iff (!nrst)
        (reg_rd && reg_addr == OFF_PIN_LEVEL) |=> ((reg_rdata[5:0] & $past(analog_select_ff)) == NO_PINS);
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero"); // RULE11

    property p_aout_hiz;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |=> ((pad_ctrl.drive_oe & $past(periph_req.analog_out_on)) == NO_PINS);
    endproperty
    a_aout_hiz: assert property (p_aout_hiz) else $error("analog output pin still driven"); // RULE9

    property p_od_sink;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |=> ((pad_ctrl.drive_out & $past(open_drain_select_ff)) == NO_PINS);
    endproperty
    a_od_sink: assert property (p_od_sink) else $error("open-drain pin driven high"); // RULE15

    property p_master_clear_input_pu;
        @(posedge mclk) disable iff (!nrst)
        mcle_sync_ff |=> pad_ctrl.pullup_on[INPUT_ONLY_BIT];
    endproperty
    a_master_clear_input_pu: assert property (p_master_clear_input_pu) else $error("input-only pull-up off"); // RULE21

    property p_pp_pu;
        @(posedge mclk) disable iff (!nrst)
        1'b1 |=> ((pad_ctrl.pullup_on & pad_ctrl.drive_oe & ~pad_ctrl.drive_out) == NO_PINS);
    endproperty
    a_pp_pu: assert property (p_pp_pu) else $error("pull-up on against low drive"); // RULE22

    property p_upper_zero;
        @(posedge mclk) disable iff (!nrst)
        reg_rd |=> reg_rdata[7:6] == UPPER_ZERO ##1 reg_rdata == READ_ZERO || $past(reg_rd);
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits nonzero"); // RULE24

    property p_master_clear_input_read;
        @(posedge mclk) disable iff (!nrst)
        (mcle_sync_ff && reg_rd && reg_addr == OFF_PIN_LEVEL) |=> reg_rdata[INPUT_ONLY_BIT];
    endproperty
    a_master_clear_input_read: assert property (p_master_clear_input_read) else $error("input-only pin read zero"); // RULE23

    property p_pin_read;
        @(posedge mclk) disable iff (!nrst)
        (reg_rd && reg_addr == OFF_PIN_LEVEL && !mcle_sync_ff && $past(nrst) && $past(nrst, 2))
        |=> reg_rdata[PIN_W-1:0] == ($past(pin_in, 3) & ~$past(analog_select_ff));
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin-level read differs from pins"); // RULE4

    property p_sync_depth;
        @(posedge mclk) disable iff (!nrst)
        $past(nrst) |=> pin_sync_ff == $past(pin_in, 2);
    endproperty
    a_sync_depth: assert property (p_sync_depth) else $error("pin synchroniser depth wrong"); // RULE25

    property p_bit_set;
        @(posedge mclk) disable iff (!nrst)
        (reg_wr && reg_addr == OFF_PIN_BIT_SET)
        |=> output_latch_ff == (($past(pin_read) | $past(wdata6)) & DRIVEN_PINS);
    endproperty
    a_bit_set: assert property (p_bit_set) else $error("bit-set write lost pin state"); // RULE5

    property p_bit_clr;
        @(posedge mclk) disable iff (!nrst)
        (reg_wr && reg_addr == OFF_PIN_BIT_CLEAR)
        |=> output_latch_ff == ($past(pin_read) & ~$past(wdata6) & DRIVEN_PINS);
    endproperty
    a_bit_clr: assert property (p_bit_clr) else $error("bit-clear write lost pin state"); // RULE5

    property p_periph_drive;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> ((pad_ctrl.drive_out ^ $past(periph_req.data_out)) &
            $past(periph_req.owns_pin & ~od_eff)) == NO_PINS;
    endproperty
    a_periph_drive: assert property (p_periph_drive) else $error("owned pin not driven by peripheral"); // RULE8

    property p_latch_drive;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> ((pad_ctrl.drive_out ^ $past(output_latch_ff)) &
            $past(~periph_req.owns_pin & ~od_eff)) == NO_PINS;
    endproperty
    a_latch_drive: assert property (p_latch_drive) else $error("free pin not driven by latch"); // RULE7

    property p_buf_off;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> pad_ctrl.digital_in_on == ~$past(analog_select_ff);
    endproperty
    a_buf_off: assert property (p_buf_off) else $error("input buffer state wrong"); // RULE10

    property p_ans_no_drive;
        @(posedge mclk) disable iff (!nrst)
        ($changed(analog_select_ff) && $stable(pin_direction_ff) && $stable(output_latch_ff) &&
            $stable(open_drain_select_ff) && $stable(periph_req))
        |=> $stable(pad_ctrl.drive_oe) && $stable(pad_ctrl.drive_out);
    endproperty
    a_ans_no_drive: assert property (p_ans_no_drive) else $error("analog select changed drive"); // RULE12

    property p_dir_analog;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> ($past(~pin_direction_ff & analog_select_ff & ~periph_req.analog_out_on & ~od_eff & DRIVEN_PINS) &
            ~pad_ctrl.drive_oe) == NO_PINS;
    endproperty
    a_dir_analog: assert property (p_dir_analog) else $error("analog output pin not driven"); // RULE13

    property p_twi_od;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> (pad_ctrl.drive_out & $past(periph_req.owns_pin & periph_req.two_wire_owns)) == NO_PINS;
    endproperty
    a_twi_od: assert property (p_twi_od) else $error("two-wire pin driven high"); // RULE16

    property p_slew;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> pad_ctrl.slew_limited == $past(slew_limit_select_ff);
    endproperty
    a_slew: assert property (p_slew) else $error("slew control not applied"); // RULE17

    property p_thresh;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> pad_ctrl.schmitt_sel == $past(input_threshold_select_ff);
    endproperty
    a_thresh: assert property (p_thresh) else $error("threshold select not applied"); // RULE18

    property p_pu_bit;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> ((pad_ctrl.pullup_on ^ $past(weak_pullup_enable_ff)) & $past(pin_direction_ff) & ~INPUT_ONLY_MASK) == NO_PINS;
    endproperty
    a_pu_bit: assert property (p_pu_bit) else $error("input pull-up differs from its bit"); // RULE20

    property p_reset_mode;
        @(posedge mclk) disable iff (!nrst)
        $rose(nrst) |-> analog_select_ff == RST_ANALOG_SELECT && output_latch_ff == RST_OUTPUT_LATCH;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("analog select not in analog mode"); // RULE14

    property p_pu_out_off;
        @(posedge mclk) disable iff (!nrst)
        1'h1 |=> (pad_ctrl.pullup_on & $past(~pin_direction_ff & ~od_eff)) == NO_PINS;
    endproperty
    a_pu_out_off: assert property (p_pu_out_off) else $error("pull-up on push-pull output"); // RULE22

endmodule

// ---- pad_board_model.sv ----
// Board-side model that resolves each pin level from the port's pad controls.
`timescale 1ns/1ns
module pad_board_model (
    // Pad controls from the port
    input wire gpio_port_pkg::pad_ctrl_t pad_ctrl,
    // Level applied by an external source
    input wire logic [5:0] ext_level,
    // Resolved pin levels
    output logic [5:0] pin_level
);
    import gpio_port_pkg::*;
    // A released pin follows its pull-up first, so an idle line never floats to a guess.
    assign pin_level = (pad_ctrl.drive_oe & pad_ctrl.drive_out) |
        (~pad_ctrl.drive_oe & (pad_ctrl.pullup_on | ext_level));
endmodule

// ---- six_bit_gpio_port_bench.sv ----
// Self-checking bench for the six-bit GPIO port.
`timescale 1ns/1ns
module six_bit_gpio_port_bench;
    import gpio_port_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [5:0] pin_in;
    logic [5:0] periph_in;
    logic [5:0] ext_level = 6'h00;
    logic strap = 1'b1;
    pad_ctrl_t pad_ctrl;
    pad_ctrl_t pe;
    periph_req_t preq = '0;
    logic [5:0] rg [8];
    logic [7:0] rd_val;
    int errors = 0;
    int num_checks = 0;
    int off;

    always #5 mclk = ~mclk;

    six_bit_gpio_port i_six_bit_gpio_port (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pad_ctrl(pad_ctrl), .master_clear_function_enable(strap), .periph_req(preq), .periph_in(periph_in));
    pad_board_model i_pad_board_model (.pad_ctrl(pad_ctrl), .ext_level(ext_level), .pin_level(pin_in));

    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chk6(input logic [5:0] seen, input logic [5:0] exp);
        chk({2'h0, seen}, {2'h0, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // A write and a read on consecutive edges, as the bus allows.
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] v, input logic [3:0] b);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= b;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    // ==========================================================
    // Expected pad state from the shadow registers
    function automatic pad_ctrl_t exp_pad();
        pad_ctrl_t p;
        logic [5:0] val;
        logic [5:0] odv;
        val = (preq.owns_pin & preq.data_out) | (~preq.owns_pin & rg[1]);
        odv = rg[5] | (preq.owns_pin & preq.two_wire_owns);
        p.drive_oe = ~rg[2] & ~preq.analog_out_on & ~(odv & val) & DRIVEN_PINS;
        p.drive_out = val & p.drive_oe;
        p.pullup_on = (rg[4] & (rg[2] | (odv & val))) | (strap ? INPUT_ONLY_MASK : NO_PINS);
        p.slew_limited = rg[6];
        p.schmitt_sel = rg[7];
        p.digital_in_on = ~rg[3];
        return p;
    endfunction

    function automatic logic [5:0] exp_read();
        pad_ctrl_t p;
        logic [5:0] lvl;
        p = exp_pad();
        lvl = p.drive_out | (~p.drive_oe & (p.pullup_on | ext_level));
        return (lvl & ~rg[3]) | (strap ? INPUT_ONLY_MASK : NO_PINS);
    endfunction

    // Bit writes sample the pins, so the pins must settle before the expected latch is formed.
    task automatic put(input int o, input logic [7:0] v);
        logic [5:0] pr;
        if (o == 8 || o == 9) repeat (8) @(posedge mclk);
        pr = exp_read();
        wr(o[3:0], v);
        if (o == 0) rg[1] = v[5:0] & DRIVEN_PINS;
        else if (o == 8) rg[1] = (pr | v[5:0]) & DRIVEN_PINS;
        else if (o == 9) rg[1] = pr & ~v[5:0] & DRIVEN_PINS;
        else if (o < 8) rg[o] = (v[5:0] & ((o == 4 || o == 7) ? ALL_PINS : DRIVEN_PINS)) |
            (o == 2 ? INPUT_ONLY_MASK : NO_PINS);
    endtask

    task automatic check_all();
        repeat (8) @(posedge mclk);
        #1 pe = exp_pad();
        chk6(pad_ctrl.drive_oe, pe.drive_oe);
        chk6(pad_ctrl.drive_out & pad_ctrl.drive_oe, pe.drive_out);
        chk6(pad_ctrl.pullup_on, pe.pullup_on);
        chk6(pad_ctrl.slew_limited, pe.slew_limited);
        chk6(pad_ctrl.schmitt_sel, pe.schmitt_sel);
        chk6(pad_ctrl.digital_in_on, pe.digital_in_on);
        chk6(periph_in, exp_read());
        for (int o = 0; o < 16; o++) begin
            rd(o[3:0]);
            chk(rd_val, o == 0 ? {2'h0, exp_read()} : (o < 8 ? {2'h0, rg[o]} : READ_ZERO));
        end
    endtask

    task automatic reset_dut();
        nrst <= 1'b0;
        preq <= '0;
        rg = '{NO_PINS, RST_OUTPUT_LATCH, RST_PIN_DIRECTION, RST_ANALOG_SELECT, RST_WEAK_PULLUP,
            RST_OPEN_DRAIN, RST_SLEW_LIMIT, RST_INPUT_THRESHOLD};
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Test sequence
    initial begin
        void'($urandom(97266));
        reset_dut();
        check_all();
        $display("reset values test done");
        for (int i = 0; i < 40; i++) begin
            @(posedge mclk);
            ext_level <= 6'($urandom);
            strap <= 1'($urandom);
            preq <= (i < 15) ? '0 : {18'($urandom), 6'h00};
            @(posedge mclk);
            repeat (3) begin
                off = $urandom_range(15);
                if (off == 7 && preq.owns_pin != NO_PINS) off = 6;
                put(off, 8'($urandom));
            end
            check_all();
        end
        $display("random register and pin test done");
        repeat (8) begin
            off = $urandom;
            wr_rd(OFF_PIN_LEVEL, 8'(off), OFF_OUTPUT_LATCH);
            rg[1] = 6'(off) & DRIVEN_PINS;
            chk(rd_val, {2'h0, rg[1]});
        end
        $display("back-to-back write and read test done");
        put(2, 8'h00);
        put(5, 8'h00);
        @(posedge mclk);
        preq <= {18'h00000, ALL_PINS};
        repeat (3) @(posedge mclk);
        #1 chk6(pad_ctrl.drive_oe, NO_PINS);
        @(posedge mclk);
        preq <= '0;
        check_all();
        $display("analog output priority test done");
        @(posedge mclk);
        reset_dut();
        check_all();
        $display("second reset test done");
        final_report();
    end

    initial begin
        #200000;
        errors++;
        final_report();
    end
endmodule
